// ==== hw/lock_loop_pkg.sv ====
// constants for the lock loop control register block
package lock_loop_pkg;
   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_LOOP1_REF_SOURCE_SEL = 16'h0176;
   localparam logic [15:0] OFS_LOOP1_GAIN_CTRL = 16'h0179;
   localparam logic [15:0] OFS_LOOP1_SYNC_ENABLE = 16'h0181;
   localparam logic [15:0] OFS_LOOP1_SYNC_INTEGER = 16'h0182;
   localparam logic [15:0] OFS_LOOP1_SYNC_NUMERATOR = 16'h0183;
   localparam logic [15:0] OFS_LOOP1_SYNC_DENOMINATOR = 16'h0184;
   localparam logic [15:0] OFS_LOOP1_SYNC_RATIO = 16'h0185;
   localparam logic [15:0] OFS_LOOP1_SYNC_REF_SELECT = 16'h0186;
   localparam logic [15:0] OFS_LOOP1_SYNC_GAIN_BW = 16'h0187;
   localparam logic [15:0] OFS_LOOP2_ENABLE_CTRL = 16'h0191;
   localparam logic [15:0] OFS_LOOP2_UPDATE_INTEGER = 16'h0192;
   localparam logic [15:0] OFS_LOOP2_NUMERATOR = 16'h0193;
   localparam logic [15:0] OFS_LOOP2_DENOMINATOR = 16'h0194;
   localparam logic [15:0] OFS_LOOP2_RATIO_OUTDIV = 16'h0195;
   localparam logic [15:0] OFS_LOOP2_REF_SELECT_DIV = 16'h0196;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POS_ENABLE = 0;
   localparam int POS_UPDATE = 15;
   localparam int POS_INT_LSB = 0;
   localparam int INT_W = 10;
   localparam int POS_VCO_LSB = 8;
   localparam int VCO_W = 4;
   localparam int SYNC_VCO_W = 3;
   localparam int POS_OUTDIV_LSB = 1;
   localparam int OUTDIV_W = 3;
   localparam int POS_PREDIV_LSB = 6;
   localparam int PREDIV_W = 2;
   localparam int POS_SRC_LSB = 0;
   localparam int SRC_W = 4;
   localparam int POS_GAIN_LSB = 2;
   localparam int GAIN_W = 4;
   localparam int POS_BW = 0;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [9:0] RST_INTEGER = 10'h008;
   localparam logic [15:0] RST_NUMERATOR = 16'h0018;
   localparam logic [15:0] RST_DENOMINATOR = 16'h007d;
   localparam logic [2:0] RST_OUTDIV2 = 3'h6;
   localparam logic [9:0] RST_SYNC_INTEGER = 10'h000;
   localparam logic [15:0] RST_SYNC_FRACTION = 16'h0000;
   localparam logic RST_SYNC_BW = 1'b1;
   // ----------------------------------------------------------------
   // decode limits
   // ----------------------------------------------------------------
   localparam logic [2:0] OUTDIV_MIN = 3'h2;
   localparam logic [3:0] GAIN_SAT_CODE = 4'h8;
   localparam logic [8:0] GAIN_MAX = 9'h100;
   localparam logic [15:0] SRC_VALID_MAP = 16'h573b;
endpackage

// ==== hw/ratio_shadow.sv ====
// pending and running copy of one loop ratio field
`timescale 1ns/100ps
module ratio_shadow #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic loop_enable_i,
   input wire logic write_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic update_i,
   output logic [WIDTH-1:0] pending_o,
   output logic [WIDTH-1:0] running_o
);
   // ----------------------------------------------------------------
   // pending copy, always written
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pending_o <= RESET;
      else if (write_i)
         pending_o <= wdata_i;
   end
   // ----------------------------------------------------------------
   // running copy
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         running_o <= RESET;
      else if (loop_enable_i && update_i)
         running_o <= write_i ? wdata_i : pending_o;
      else if (!loop_enable_i && write_i)
         running_o <= wdata_i;
   end
endmodule // ratio_shadow

// ==== hw/lock_loop_control_regs.sv ====
// control registers for the two frequency-locked loops
//
// Functional notes
// - update strobe applies pending ratios when enabled
// - integer multiplier 10 bits, reset eight, gated
// - fraction numerator 16 bits, reset 0x18, gated
// - fraction denominator 16 bits, reset 0x7d
// - vco ratio divides by code plus one
// - output divider code 2..7, loop two 6
// - reference predivider divides by 1,2,4,8
// - reference source select with reserved codes
// - loop gain two to code, saturates 256
// - synchroniser integer multiplier 10 bits, reset zero
// - synchroniser numerator and denominator reset zero
// - synchroniser vco ratio 1,2,4,8, else 16
// - synchroniser predivider divides by 1,2,4,8
// - synchroniser source select uses same codes
// - synchroniser gain plus bandwidth select bit
// - disabled loop takes ratio writes directly
`timescale 1ns/100ps
module lock_loop_control_regs (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic [3:0] loop1_ref_source_select_o,
   output logic loop1_ref_source_valid_o,
   output logic [3:0] loop1_ref_divide_o,
   output logic [8:0] loop1_loop_gain_o,
   output logic loop1_sync_path_enable_o,
   output logic [9:0] loop1_sync_integer_multiplier_o,
   output logic [15:0] loop1_sync_numerator_o,
   output logic [15:0] loop1_sync_denominator_o,
   output logic [4:0] loop1_sync_vco_ratio_o,
   output logic [3:0] loop1_sync_predivide_o,
   output logic [3:0] loop1_sync_source_select_o,
   output logic loop1_sync_source_valid_o,
   output logic [8:0] loop1_sync_gain_o,
   output logic loop1_sync_bandwidth_select_o,
   output logic loop2_loop_enable_o,
   output logic [9:0] loop2_integer_multiplier_o,
   output logic [15:0] loop2_fraction_numerator_o,
   output logic [15:0] loop2_fraction_denominator_o,
   output logic [4:0] loop2_vco_ratio_o,
   output logic [2:0] loop2_output_divider_o,
   output logic loop2_output_divider_valid_o,
   output logic [3:0] loop2_ref_predivide_o,
   output logic [3:0] loop2_ref_source_select_o,
   output logic loop2_ref_source_valid_o
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [8:0] gain_value(input logic [3:0] code);
      logic [8:0] result;
      result = 9'h001;
      if (code >= lock_loop_pkg::GAIN_SAT_CODE)
         result = lock_loop_pkg::GAIN_MAX;
      else
         result = 9'(9'h001 << code[2:0]);
      return result;
   endfunction

   function automatic logic [3:0] predivide_value(input logic [1:0] code);
      return 4'(4'h1 << code);
   endfunction

   function automatic logic src_valid(input logic [3:0] code);
      return lock_loop_pkg::SRC_VALID_MAP[code];
   endfunction

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic wr_l1_src;
   logic wr_l1_gain;
   logic wr_l1_sen;
   logic wr_l1_sint;
   logic wr_l1_snum;
   logic wr_l1_sden;
   logic wr_l1_sratio;
   logic wr_l1_ssel;
   logic wr_l1_sgain;
   logic wr_l2_en;
   logic wr_l2_int;
   logic wr_l2_num;
   logic wr_l2_den;
   logic wr_l2_ratio;
   logic wr_l2_sel;
   logic update_pulse;

   assign wr_l1_src = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_REF_SOURCE_SEL);
   assign wr_l1_gain = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_GAIN_CTRL);
   assign wr_l1_sen = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_ENABLE);
   assign wr_l1_sint = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_INTEGER);
   assign wr_l1_snum = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_NUMERATOR);
   assign wr_l1_sden = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_DENOMINATOR);
   assign wr_l1_sratio = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_RATIO);
   assign wr_l1_ssel = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_REF_SELECT);
   assign wr_l1_sgain = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP1_SYNC_GAIN_BW);
   assign wr_l2_en = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_ENABLE_CTRL);
   assign wr_l2_int = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_UPDATE_INTEGER);
   assign wr_l2_num = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_NUMERATOR);
   assign wr_l2_den = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_DENOMINATOR);
   assign wr_l2_ratio = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_RATIO_OUTDIV);
   assign wr_l2_sel = reg_write_i && (reg_addr_i == lock_loop_pkg::OFS_LOOP2_REF_SELECT_DIV);
   // strobe is never stored, only decoded from the write
   assign update_pulse = wr_l2_int && reg_wdata_i[lock_loop_pkg::POS_UPDATE];

   // ----------------------------------------------------------------
   // loop one fields
   // ----------------------------------------------------------------
   logic [3:0] l1_src_reg;
   logic [1:0] l1_prediv_reg;
   logic [3:0] l1_gain_reg;

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         l1_src_reg <= 4'h0;
         l1_prediv_reg <= 2'h0;
      end
      else if (wr_l1_src)
      begin
         l1_src_reg <= reg_wdata_i[lock_loop_pkg::POS_SRC_LSB +: lock_loop_pkg::SRC_W];
         l1_prediv_reg <= reg_wdata_i[lock_loop_pkg::POS_PREDIV_LSB +: lock_loop_pkg::PREDIV_W];
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         l1_gain_reg <= 4'h0;
      else if (wr_l1_gain)
         l1_gain_reg <= reg_wdata_i[lock_loop_pkg::POS_GAIN_LSB +: lock_loop_pkg::GAIN_W];
   end

   // ----------------------------------------------------------------
   // loop one synchroniser path
   // ----------------------------------------------------------------
   logic s1_en_reg;
   logic [9:0] s1_int_reg;
   logic [15:0] s1_num_reg;
   logic [15:0] s1_den_reg;
   logic [2:0] s1_ratio_reg;
   logic [1:0] s1_prediv_reg;
   logic [3:0] s1_src_reg;
   logic [3:0] s1_gain_reg;
   logic s1_bw_reg;

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         s1_en_reg <= 1'b0;
      else if (wr_l1_sen)
         s1_en_reg <= reg_wdata_i[lock_loop_pkg::POS_ENABLE];
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s1_int_reg <= lock_loop_pkg::RST_SYNC_INTEGER;
         s1_num_reg <= lock_loop_pkg::RST_SYNC_FRACTION;
         s1_den_reg <= lock_loop_pkg::RST_SYNC_FRACTION;
      end
      else
      begin
         if (wr_l1_sint)
            s1_int_reg <= reg_wdata_i[lock_loop_pkg::POS_INT_LSB +: lock_loop_pkg::INT_W];
         if (wr_l1_snum)
            s1_num_reg <= reg_wdata_i;
         if (wr_l1_sden)
            s1_den_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s1_ratio_reg <= 3'h0;
         s1_prediv_reg <= 2'h0;
         s1_src_reg <= 4'h0;
         s1_gain_reg <= 4'h0;
         s1_bw_reg <= lock_loop_pkg::RST_SYNC_BW;
      end
      else
      begin
         if (wr_l1_sratio)
            s1_ratio_reg <= reg_wdata_i[lock_loop_pkg::POS_VCO_LSB +: lock_loop_pkg::SYNC_VCO_W];
         if (wr_l1_ssel)
         begin
            s1_prediv_reg <= reg_wdata_i[lock_loop_pkg::POS_PREDIV_LSB +: lock_loop_pkg::PREDIV_W];
            s1_src_reg <= reg_wdata_i[lock_loop_pkg::POS_SRC_LSB +: lock_loop_pkg::SRC_W];
         end
         if (wr_l1_sgain)
         begin
            s1_gain_reg <= reg_wdata_i[lock_loop_pkg::POS_GAIN_LSB +: lock_loop_pkg::GAIN_W];
            s1_bw_reg <= reg_wdata_i[lock_loop_pkg::POS_BW];
         end
      end
   end

   // ----------------------------------------------------------------
   // loop two main path
   // ----------------------------------------------------------------
   logic l2_en_reg;
   logic [9:0] l2_int_pending;
   logic [15:0] l2_num_pending;
   logic [15:0] l2_den_reg;
   logic [3:0] l2_vco_reg;
   logic [2:0] l2_outdiv_reg;
   logic [1:0] l2_prediv_reg;
   logic [3:0] l2_src_reg;

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         l2_en_reg <= 1'b0;
      else if (wr_l2_en)
         l2_en_reg <= reg_wdata_i[lock_loop_pkg::POS_ENABLE];
   end

   ratio_shadow #(
      .WIDTH(10),
      .RESET(lock_loop_pkg::RST_INTEGER)
   ) integer_shadow (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .loop_enable_i(l2_en_reg),
      .write_i(wr_l2_int),
      .wdata_i(reg_wdata_i[lock_loop_pkg::POS_INT_LSB +: lock_loop_pkg::INT_W]),
      .update_i(update_pulse),
      .pending_o(l2_int_pending),
      .running_o(loop2_integer_multiplier_o)
   );

   ratio_shadow #(
      .WIDTH(16),
      .RESET(lock_loop_pkg::RST_NUMERATOR)
   ) numerator_shadow (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .loop_enable_i(l2_en_reg),
      .write_i(wr_l2_num),
      .wdata_i(reg_wdata_i),
      .update_i(update_pulse),
      .pending_o(l2_num_pending),
      .running_o(loop2_fraction_numerator_o)
   );

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         l2_den_reg <= lock_loop_pkg::RST_DENOMINATOR;
      else if (wr_l2_den)
         l2_den_reg <= reg_wdata_i;
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         l2_vco_reg <= 4'h0;
         l2_outdiv_reg <= lock_loop_pkg::RST_OUTDIV2;
      end
      else if (wr_l2_ratio)
      begin
         l2_vco_reg <= reg_wdata_i[lock_loop_pkg::POS_VCO_LSB +: lock_loop_pkg::VCO_W];
         l2_outdiv_reg <= reg_wdata_i[lock_loop_pkg::POS_OUTDIV_LSB +: lock_loop_pkg::OUTDIV_W];
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         l2_prediv_reg <= 2'h0;
         l2_src_reg <= 4'h0;
      end
      else if (wr_l2_sel)
      begin
         l2_prediv_reg <= reg_wdata_i[lock_loop_pkg::POS_PREDIV_LSB +: lock_loop_pkg::PREDIV_W];
         l2_src_reg <= reg_wdata_i[lock_loop_pkg::POS_SRC_LSB +: lock_loop_pkg::SRC_W];
      end
   end

   // ----------------------------------------------------------------
   // decoded outputs
   // ----------------------------------------------------------------
   assign loop1_ref_source_select_o = l1_src_reg;
   assign loop1_ref_source_valid_o = src_valid(l1_src_reg);
   assign loop1_ref_divide_o = predivide_value(l1_prediv_reg);
   assign loop1_loop_gain_o = gain_value(l1_gain_reg);
   assign loop1_sync_path_enable_o = s1_en_reg;
   assign loop1_sync_integer_multiplier_o = s1_int_reg;
   assign loop1_sync_numerator_o = s1_num_reg;
   assign loop1_sync_denominator_o = s1_den_reg;
   assign loop1_sync_vco_ratio_o = s1_ratio_reg[2] ? 5'h10 : 5'(5'h01 << s1_ratio_reg[1:0]);
   assign loop1_sync_predivide_o = predivide_value(s1_prediv_reg);
   assign loop1_sync_source_select_o = s1_src_reg;
   assign loop1_sync_source_valid_o = src_valid(s1_src_reg);
   assign loop1_sync_gain_o = gain_value(s1_gain_reg);
   assign loop1_sync_bandwidth_select_o = s1_bw_reg;
   assign loop2_loop_enable_o = l2_en_reg;
   assign loop2_fraction_denominator_o = l2_den_reg;
   assign loop2_vco_ratio_o = 5'({1'b0, l2_vco_reg} + 5'h01);
   assign loop2_output_divider_o = l2_outdiv_reg;
   assign loop2_output_divider_valid_o = (l2_outdiv_reg >= lock_loop_pkg::OUTDIV_MIN);
   assign loop2_ref_predivide_o = predivide_value(l2_prediv_reg);
   assign loop2_ref_source_select_o = l2_src_reg;
   assign loop2_ref_source_valid_o = src_valid(l2_src_reg);

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   logic [15:0] read_next;

   always_comb
   begin
      read_next = 16'h0000;
      case (reg_addr_i)
         lock_loop_pkg::OFS_LOOP1_REF_SOURCE_SEL: read_next = {8'h00, l1_prediv_reg, 2'h0, l1_src_reg};
         lock_loop_pkg::OFS_LOOP1_GAIN_CTRL: read_next = {10'h000, l1_gain_reg, 2'h0};
         lock_loop_pkg::OFS_LOOP1_SYNC_ENABLE: read_next = {15'h0000, s1_en_reg};
         lock_loop_pkg::OFS_LOOP1_SYNC_INTEGER: read_next = {6'h00, s1_int_reg};
         lock_loop_pkg::OFS_LOOP1_SYNC_NUMERATOR: read_next = s1_num_reg;
         lock_loop_pkg::OFS_LOOP1_SYNC_DENOMINATOR: read_next = s1_den_reg;
         lock_loop_pkg::OFS_LOOP1_SYNC_RATIO: read_next = {5'h00, s1_ratio_reg, 8'h00};
         lock_loop_pkg::OFS_LOOP1_SYNC_REF_SELECT: read_next = {8'h00, s1_prediv_reg, 2'h0, s1_src_reg};
         lock_loop_pkg::OFS_LOOP1_SYNC_GAIN_BW: read_next = {10'h000, s1_gain_reg, 1'b0, s1_bw_reg};
         lock_loop_pkg::OFS_LOOP2_ENABLE_CTRL: read_next = {15'h0000, l2_en_reg};
         lock_loop_pkg::OFS_LOOP2_UPDATE_INTEGER: read_next = {6'h00, l2_int_pending};
         lock_loop_pkg::OFS_LOOP2_NUMERATOR: read_next = l2_num_pending;
         lock_loop_pkg::OFS_LOOP2_DENOMINATOR: read_next = l2_den_reg;
         lock_loop_pkg::OFS_LOOP2_RATIO_OUTDIV: read_next = {4'h0, l2_vco_reg, 4'h0, l2_outdiv_reg, 1'b0};
         lock_loop_pkg::OFS_LOOP2_REF_SELECT_DIV: read_next = {8'h00, l2_prediv_reg, 2'h0, l2_src_reg};
         default: read_next = 16'h0000;
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_rdata_o <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_read_i;
         if (reg_read_i)
            reg_rdata_o <= read_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   strobe_applies_a: assert property (l2_en_reg && update_pulse |=> loop2_fraction_numerator_o == $past(l2_num_pending)
      && loop2_integer_multiplier_o == $past(reg_wdata_i[9:0]))
      else $error("update strobe did not apply numerator");
   integer_gated_a: assert property (l2_en_reg && wr_l2_int && !reg_wdata_i[15]
      |=> $stable(loop2_integer_multiplier_o))
      else $error("integer changed without strobe");
   numerator_gated_a: assert property (l2_en_reg && wr_l2_num |=> $stable(loop2_fraction_numerator_o))
      else $error("numerator changed without strobe");
   direct_write_a: assert property (!l2_en_reg && wr_l2_int
      |=> loop2_integer_multiplier_o == $past(reg_wdata_i[9:0]))
      else $error("disabled loop did not take integer");
   strobe_reads_zero_a: assert property (reg_read_i && reg_addr_i == lock_loop_pkg::OFS_LOOP2_UPDATE_INTEGER
      |=> reg_rvalid_o && !reg_rdata_o[15])
      else $error("update strobe read back as one");
   denominator_write_a: assert property (wr_l2_den |=> loop2_fraction_denominator_o == $past(reg_wdata_i))
      else $error("denominator write lost");
   vco_ratio_a: assert property (wr_l2_ratio
      |=> loop2_vco_ratio_o == 5'({1'b0, $past(reg_wdata_i[11:8])} + 5'h01))
      else $error("vco ratio not code plus one");
   outdiv_valid_a: assert property (loop2_output_divider_valid_o == (loop2_output_divider_o > 3'h1))
      else $error("output divider reserved flag wrong");
   gain_saturate_a: assert property (l1_gain_reg[3] |-> loop1_loop_gain_o == 9'h100)
      else $error("loop gain not saturated");
   sync_ratio_a: assert property (s1_ratio_reg == 3'h3 |-> loop1_sync_vco_ratio_o == 5'h08)
      else $error("sync vco ratio wrong");
   source_reserved_a: assert property (loop2_ref_source_select_o == 4'h2 |-> !loop2_ref_source_valid_o)
      else $error("reserved source accepted");
   sync_source_a: assert property (s1_src_reg == 4'he |-> loop1_sync_source_valid_o)
      else $error("sync source code rejected");

   strobe_cover_c: cover property (l2_en_reg && update_pulse);
   direct_cover_c: cover property (!l2_en_reg && wr_l2_num);
   gated_cover_c: cover property (l2_en_reg && wr_l2_int ##[1:20] update_pulse);
   sync_enable_cover_c: cover property (wr_l1_sen && reg_wdata_i[0]);
endmodule // lock_loop_control_regs

// ==== testbench/host_model.sv ====
// host bus master model for the lock loop control registers
`timescale 1ns/100ps
module host_model (
   input wire logic clock_i,
   output logic [15:0] reg_addr_o,
   output logic reg_write_o,
   output logic reg_read_o,
   output logic [15:0] reg_wdata_o,
   input wire logic [15:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial
   begin
      reg_addr_o = 16'h0000;
      reg_write_o = 1'b0;
      reg_read_o = 1'b0;
      reg_wdata_o = 16'h0000;
   end
   // idle bus shows inverted values, never the last request
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_write_o = 1'b1;
      @(posedge clock_i);
      #1;
      reg_write_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   task rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      @(posedge clock_i);
      #1;
      reg_addr_o = a;
      reg_read_o = 1'b1;
      @(posedge clock_i);
      #1;
      reg_read_o = 1'b0;
      reg_addr_o = ~a;
      ok = (reg_rvalid_i === 1'b1);
      d = reg_rdata_i;
   endtask
endmodule // host_model

// ==== testbench/tb_lock_loop_control_regs.sv ====
// self-checking bench for the lock loop control registers
`timescale 1ns/100ps
module tb_lock_loop_control_regs;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [15:0] addr, wdata, rdata, num, den, v, t_new, snum, sden;
   logic wr_s, rd_s, rvalid, bw, ovld, svld, ok, svld1, svlds, sen, en2;
   logic [8:0] gain, sgain;
   logic [4:0] svco, vco;
   logic [9:0] nint, n_new, sint;
   logic [3:0] pdiv, pdiv1, pdivs, s1, ss, s2;
   logic [2:0] odiv;
   integer mismatches = 0;
   integer checks_done = 0;
   integer seed = 27;
   integer i;
   always #10 clock_i = ~clock_i;
   host_model host (.clock_i(clock_i), .reg_addr_o(addr), .reg_write_o(wr_s), .reg_read_o(rd_s),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   lock_loop_control_regs DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_write_i(wr_s),
      .reg_read_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .loop1_ref_source_select_o(s1), .loop1_ref_source_valid_o(svld1), .loop1_ref_divide_o(pdiv1),
      .loop1_loop_gain_o(gain), .loop1_sync_path_enable_o(sen), .loop1_sync_integer_multiplier_o(sint),
      .loop1_sync_numerator_o(snum), .loop1_sync_denominator_o(sden), .loop1_sync_vco_ratio_o(svco),
      .loop1_sync_predivide_o(pdivs), .loop1_sync_source_select_o(ss), .loop1_sync_source_valid_o(svlds),
      .loop1_sync_gain_o(sgain), .loop1_sync_bandwidth_select_o(bw), .loop2_loop_enable_o(en2),
      .loop2_integer_multiplier_o(nint), .loop2_fraction_numerator_o(num), .loop2_fraction_denominator_o(den),
      .loop2_vco_ratio_o(vco), .loop2_output_divider_o(odiv), .loop2_output_divider_valid_o(ovld),
      .loop2_ref_predivide_o(pdiv), .loop2_ref_source_select_o(s2), .loop2_ref_source_valid_o(svld));
   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task rchk(input logic [15:0] a, input logic [15:0] exp);
      host.rd(a, v, ok);
      check("rvalid", 16'(ok), 16'h0001);
      check("rdata", v, exp);
   endtask
   function automatic logic [15:0] gain_of(input int c);
      return (c >= 8) ? 16'h0100 : 16'(1 << c);
   endfunction
   function automatic logic [15:0] src_ok(input int c);
      return 16'(c inside {0, 1, 3, 4, 5, 8, 9, 10, 12, 14});
   endfunction
   initial
   begin
      repeat (3000) @(posedge clock_i);
      mismatches = mismatches + 1;
      give_verdict;
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clock_i);
      #1;
      arst_n_i = 1'b1;
      check("outdiv reset", 16'(odiv), 16'h0006);
      check("bandwidth", 16'(bw), 16'h0001);
      rchk(16'h0192, 16'h0008);
      rchk(16'h0193, 16'h0018);
      rchk(16'h0194, 16'h007d);
      rchk(16'h0182, 16'h0000);
      rchk(16'h0184, 16'h0000);
      rchk(16'h01ff, 16'h0000);
      host.wr(16'h0192, 16'h8011);
      check("integer", 16'(nint), 16'h0011);
      rchk(16'h0192, 16'h0011);
      // top bit set and offset keep both apart from the old values
      n_new = 10'($random(seed)) | 10'h200;
      t_new = 16'($unsigned($random(seed)) % 100 + 25);
      host.wr(16'h0182, {6'h00, n_new});
      host.wr(16'h0183, t_new);
      host.wr(16'h0184, t_new ^ 16'h5a5a);
      host.wr(16'h0181, 16'h0001);
      check("sync enable", 16'(sen), 16'h0001);
      check("sync integer", 16'(sint), 16'(n_new));
      check("sync numerator", snum, t_new);
      check("sync denominator", sden, t_new ^ 16'h5a5a);
      rchk(16'h0183, t_new);
      host.wr(16'h0191, 16'h0001);
      check("enable", 16'(en2), 16'h0001);
      host.wr(16'h0193, t_new);
      host.wr(16'h0192, {6'h00, n_new});
      check("integer held", 16'(nint), 16'h0011);
      check("numerator held", num, 16'h0018);
      rchk(16'h0193, t_new);
      host.wr(16'h0192, {6'h20, n_new});
      check("integer applied", 16'(nint), 16'(n_new));
      check("numerator applied", num, t_new);
      host.wr(16'h0194, t_new ^ 16'h5a5a);
      check("denominator", den, t_new ^ 16'h5a5a);
      for (i = 0; i < 16; i = i + 1)
      begin
         host.wr(16'h0195, 16'((i << 8) | ((i & 7) << 1)));
         check("vco", 16'(vco), 16'(i + 1));
         check("outdiv", 16'(odiv), 16'(i & 7));
         check("outdiv ok", 16'(ovld), 16'((i & 7) >= 2));
         host.wr(16'h0176, 16'(((i & 3) << 6) | i));
         host.wr(16'h0186, 16'(((i & 3) << 6) | i));
         host.wr(16'h0196, 16'(((i & 3) << 6) | i));
         check("predivide", 16'(pdiv), 16'(1 << (i & 3)));
         check("ref1 predivide", 16'(pdiv1), 16'(1 << (i & 3)));
         check("sync predivide", 16'(pdivs), 16'(1 << (i & 3)));
         check("source", 16'(s2), 16'(i));
         check("ref1 source", 16'(s1), 16'(i));
         check("sync source", 16'(ss), 16'(i));
         check("source ok", 16'(svld), src_ok(i));
         check("ref1 source ok", 16'(svld1), src_ok(i));
         check("sync source ok", 16'(svlds), src_ok(i));
         host.wr(16'h0179, 16'(i << 2));
         check("gain", 16'(gain), gain_of(i));
         host.wr(16'h0187, 16'((i << 2) | (i & 1)));
         check("sync gain", 16'(sgain), gain_of(i));
         check("sync bandwidth", 16'(bw), 16'(i & 1));
         host.wr(16'h0185, 16'((i & 7) << 8));
         check("sync vco", 16'(svco), (i & 4) != 0 ? 16'h0010 : 16'(1 << (i & 3)));
      end
      give_verdict;
   end
endmodule // tb_lock_loop_control_regs
